// file: rtl/tr_switch_serial_ctrl.sv
// Serial channel control with daisy chain outputs and strap overrides
`timescale 1ns/1ps
module tr_switch_serial_ctrl #(
    parameter int CH = tr_switch_pkg::CHANNELS
) (
    input  wire logic          mclk_in,
    input  wire logic          rst_in,
    input  wire logic          ce_in,
    input  wire logic          serial_clock_in,
    input  wire logic          serial_data_in,
    input  wire logic          select_in_n,
    input  wire logic          serial_enable_strap_in,
    input  wire logic          force_all_off_strap_in,
    output logic               serial_data_out_buf,
    output logic               select_out_buf,
    output logic               serial_clock_out_buf,
    output logic [CH-1:0]      channel_bias_enable_out,
    output logic [CH-1:0]      latch_state_out
);
    logic [CH-1:0] shift_reg;
    logic [CH-1:0] shift_next;
    logic          sdo_reg;
    logic [CH-1:0] latch_reg;
    logic [CH-1:0] latch_next;
    logic          sel_d_reg;
    logic [1:0]    straps_sync;
    logic          en_sync;
    logic          off_sync;
    logic          sel_sync;
    logic          sel_act_sync;
    logic [CH-1:0] bias_next;
    logic [CH-1:0] bias_reg;
    logic          shift_en;

    // Link side: the enable strap gates the shifter directly, it is a static pin on the link
    // serial port gate
    assign shift_en   = serial_enable_strap_in && !select_in_n;
    assign shift_next = {shift_reg[CH-2:0], serial_data_in};

    always_ff @(posedge serial_clock_in or posedge rst_in) begin
        if (rst_in) begin
            shift_reg <= tr_switch_pkg::SHIFT_RESET;
        end else if (shift_en) begin
            shift_reg <= shift_next;
        end
    end

    always_ff @(negedge serial_clock_in or posedge rst_in) begin
        if (rst_in) begin
            sdo_reg <= 1'b0;
        end else begin
            sdo_reg <= shift_reg[CH-1];
        end
    end

    assign serial_data_out_buf  = sdo_reg;
    assign select_out_buf       = select_in_n;
    assign serial_clock_out_buf = serial_clock_in;

    // Select and straps cross to the system clock; the shift word is stable while select is high
    level_sync #(
        .WIDTH (2)
    ) u_strap_sync (
        .clk_in   (mclk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .async_in ({serial_enable_strap_in, force_all_off_strap_in}),
        .sync_out (straps_sync)
    );
    // Select is synchronised as "selected" so the cleared sync flops match the idle pin:
    // no false select rise, and no latch load of the cleared shifter, follows reset
    level_sync #(
        .WIDTH (1)
    ) u_sel_sync (
        .clk_in   (mclk_in),
        .rst_in   (rst_in),
        .ce_in    (ce_in),
        .async_in (!select_in_n),
        .sync_out (sel_act_sync)
    );
    assign sel_sync = !sel_act_sync;
    assign en_sync  = straps_sync[1];
    assign off_sync = straps_sync[0];

    // Latch update: select rising edge copies the word; falling edge leaves it alone
    // Limitation: select must stay high at least three system clocks after the last data edge
    // latch on select rise
    assign latch_next = !en_sync                     ? tr_switch_pkg::ALL_ON :
                        (sel_sync && !sel_d_reg)     ? shift_reg :
                                                       latch_reg;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            latch_reg <= tr_switch_pkg::ALL_ON;
            sel_d_reg <= 1'b1;
        end else if (ce_in) begin
            latch_reg <= latch_next;
            sel_d_reg <= sel_sync;
        end
    end

    // Bias enables: force-off wins over everything, a one closes the channel
    // strap opens all
    assign bias_next = off_sync ? tr_switch_pkg::ALL_OFF : latch_reg;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bias_reg <= tr_switch_pkg::ALL_OFF;
        end else if (ce_in) begin
            bias_reg <= bias_next;
        end
    end

    assign channel_bias_enable_out = bias_reg;
    assign latch_state_out         = latch_reg;

    // Assertions on the system clock
    sequence s_sel_rise;
        sel_sync && !sel_d_reg && en_sync;
    endsequence

    sequence s_sel_fall;
        !sel_sync && sel_d_reg && en_sync;
    endsequence

    property p_latch_load;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in and s_sel_rise) |=> (latch_reg == $past(shift_reg));
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch missed select rise");

    property p_latch_hold;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && en_sync && !(sel_sync && !sel_d_reg)) |=> $stable(latch_reg);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without select rise");

    // A select fall must not disturb channels that are already set
    property p_sel_fall;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in and s_sel_fall) |=> $stable(latch_reg);
    endproperty
    a_sel_fall: assert property (p_sel_fall) else $error("latch changed on select fall");

    property p_preset_on;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !en_sync) |=> (latch_reg == tr_switch_pkg::ALL_ON);
    endproperty
    a_preset_on: assert property (p_preset_on) else $error("disabled latch not all on");

    property p_force_off;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && off_sync) |=> (channel_bias_enable_out == tr_switch_pkg::ALL_OFF);
    endproperty
    a_force_off: assert property (p_force_off) else $error("force off not applied");

    property p_all_closed;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !en_sync && !off_sync) ##1 (ce_in && !en_sync && !off_sync)
            |=> (channel_bias_enable_out == tr_switch_pkg::ALL_ON);
    endproperty
    a_all_closed: assert property (p_all_closed) else $error("disabled channels not closed");

    property p_all_open;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !en_sync && off_sync) |=> (channel_bias_enable_out == tr_switch_pkg::ALL_OFF);
    endproperty
    a_all_open: assert property (p_all_open) else $error("disabled channels not opened");

    property p_follow;
        @(posedge mclk_in) disable iff (rst_in)
        (ce_in && !off_sync) |=> (channel_bias_enable_out == $past(latch_reg));
    endproperty
    a_follow: assert property (p_follow) else $error("bias not following latch");

    // Assertions on the link clock
    property p_shift;
        @(posedge serial_clock_in) disable iff (rst_in)
        shift_en |=> (shift_reg == {$past(shift_reg[CH-2:0]), $past(serial_data_in)});
    endproperty
    a_shift: assert property (p_shift) else $error("shift register did not advance");

    property p_ignore;
        @(posedge serial_clock_in) disable iff (rst_in)
        !serial_enable_strap_in |=> $stable(shift_reg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("shift while port disabled");

    // Clocks seen while deselected belong to another device and must not move the word
    property p_sel_hold;
        @(posedge serial_clock_in) disable iff (rst_in)
        select_in_n |=> $stable(shift_reg);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("shift while deselected");

    property p_sdo;
        @(negedge serial_clock_in) disable iff (rst_in)
        1'b1 |=> (serial_data_out_buf == $past(shift_reg[CH-1]));
    endproperty
    a_sdo: assert property (p_sdo) else $error("data out not MSB");
endmodule // tr_switch_serial_ctrl

// file: rtl/tr_switch_pkg.sv
// Shared constants for the transmit/receive switch serial control block
package tr_switch_pkg;
    localparam int          CHANNELS      = 8;
    localparam int          MSB_POS       = CHANNELS - 1;
    localparam logic [7:0]  ALL_ON        = 8'hff;
    localparam logic [7:0]  ALL_OFF       = 8'h00;
    localparam logic [7:0]  SHIFT_RESET   = 8'h00;
    localparam int          MAX_CHAIN     = 16;
    localparam int          SCLK_MAX_MHZ  = 10;
endpackage : tr_switch_pkg

// file: rtl/level_sync.sv
// Two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (ce_in) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // level_sync

// file: tb/serial_master.sv
// Serial master model that shifts whole chain frames into the switch controls
`timescale 1ns/1ps
module serial_master (
    output logic sclk_out,
    output logic sdata_out,
    output logic sel_n_out
);
    // Clock stands low between frames, select idles high
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        sel_n_out = 1'b1;
    end
    // select low over a complete frame when sel is set, first bit first
    task automatic frame(input logic [15:0] w, input int n, input logic sel);
        sel_n_out = !sel;
        for (int i = n - 1; i >= 0; i--) begin
            sdata_out = w[i];
            #15 sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
        end
        // Released data shows the inverse so a stale bit is never taken
        sdata_out = !sdata_out;
        #15 sel_n_out = 1'b1;
        #15;
    endtask
endmodule // serial_master

// file: tb/tb_top.sv
// Testbench: two chained switch controls fed by a serial master model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic        mclk_in;
    logic        rst_in;
    logic        en_strap;
    logic        off_strap;
    logic        sclk;
    logic        sdata;
    logic        sel_n;
    logic        sdo1, sel1, sclk1, sdo2;
    logic [7:0]  bias1, latch1, bias2, latch2;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [15:0] model;
    logic [31:0] rnd = 32'h35;
    logic        ce_drive;
    bit          chain_q[$];
    int          exp_near;
    int          exp_far;

    serial_master m (.sclk_out(sclk), .sdata_out(sdata), .sel_n_out(sel_n));
    // the far device takes its serial clock, data and select from the near device's buffers
    tr_switch_serial_ctrl dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_drive), .serial_clock_in(sclk),
        .serial_data_in(sdata), .select_in_n(sel_n), .serial_enable_strap_in(en_strap),
        .force_all_off_strap_in(off_strap), .serial_data_out_buf(sdo1), .select_out_buf(sel1),
        .serial_clock_out_buf(sclk1), .channel_bias_enable_out(bias1), .latch_state_out(latch1));
    // two chained devices, well inside the sixteen device limit
    tr_switch_serial_ctrl far_dev (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_drive), .serial_clock_in(sclk1),
        .serial_data_in(sdo1), .select_in_n(sel1), .serial_enable_strap_in(en_strap),
        .force_all_off_strap_in(off_strap), .serial_data_out_buf(sdo2), .select_out_buf(),
        .serial_clock_out_buf(), .channel_bias_enable_out(bias2), .latch_state_out(latch2));

    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Chain model: one bit queue as long as the whole chain, oldest bit first
    task automatic model_frame(input logic [15:0] w, input int n);
        exp_near = 0;
        exp_far  = 0;
        for (int i = n - 1; i >= 0; i--) begin
            chain_q.push_back(w[i]);
            void'(chain_q.pop_front());
        end
        for (int i = 0; i < 8; i++) begin
            exp_far  = exp_far * 2 + chain_q[i];
            exp_near = exp_near * 2 + chain_q[i + 8];
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded wait for the latch to cross domains, then compare both devices
    task automatic settle(input logic [7:0] ne, input logic [7:0] fe);
        for (int i = 0; i < 20 && latch1 !== ne; i++)
            @(posedge mclk_in);
        repeat (4) @(posedge mclk_in);
        #1;
        `CHK("near latch", ne, latch1)
        `CHK("far latch", fe, latch2)
        `CHK("near bias", off_strap ? 8'h00 : ne, bias1)
        `CHK("far bias", off_strap ? 8'h00 : fe, bias2)
    endtask

    task automatic strap(input logic en, input logic off);
        @(posedge mclk_in);
        #1 en_strap = en;
        off_strap = off;
    endtask

    initial begin
        en_strap = 1'b1;
        off_strap = 1'b0;
        ce_drive = 1'b1;
        // Both shifters clear at reset, so the chain model starts all zero
        for (int i = 0; i < 2 * tr_switch_pkg::CHANNELS; i++)
            chain_q.push_back(1'b0);
        rst_in = 1'b1;
        repeat (3) @(posedge mclk_in);
        #1 rst_in = 1'b0;
        settle(8'hff, 8'hff);
        // Random chain frames, both latches and both data buffers checked
        for (int k = 0; k < 6; k++) begin
            rnd = xs(rnd);
            model = rnd[15:0];
            model_frame(model, 16);
            fork
                m.frame(model, 16, 1'b1);
                #100 `CHK("select buffer", sel_n, sel1)
            join
            `CHK("near data out", chain_q[8], sdo1)
            `CHK("far data out", chain_q[0], sdo2)
            settle(8'(exp_near), 8'(exp_far));
        end
        // clocks with select high, then a bare select pulse
        m.frame(~model, 16, 1'b0);
        m.frame(16'h0000, 0, 1'b1);
        settle(8'(exp_near), 8'(exp_far));
        // disabling the port presets all channels on
        strap(1'b0, 1'b0);
        settle(8'hff, 8'hff);
        // frame ignored while the port is off
        m.frame(~model, 16, 1'b1);
        strap(1'b0, 1'b1);
        settle(8'hff, 8'hff);
        // Clock enable low freezes the open channels although force-off drops
        @(posedge mclk_in);
        #1 ce_drive = 1'b0;
        off_strap = 1'b0;
        repeat (6) @(posedge mclk_in);
        #1;
        `CHK("frozen bias", 8'h00, bias1)
        ce_drive = 1'b1;
        settle(8'hff, 8'hff);
        strap(1'b1, 1'b1);
        m.frame(16'h0000, 0, 1'b1);
        settle(8'(exp_near), 8'(exp_far));
        strap(1'b1, 1'b0);
        settle(8'(exp_near), 8'(exp_far));
        end_sim();
    end

    // A hang counts as a mismatch
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule // tb_top
